/* hw/dlr_router.sv */
/*
 * dlr_router: routes forward/reverse decision points to the four overcurrent levels.
 * assumes decision points come from logic on the same clock; selections are quasi-static settings.
 */
`timescale 1ns/1ps
module dlr_router (
	input  wire logic                  i_sys_clk,                     // 20 MHz processing clock
	input  wire logic                  i_resetn,                      // async reset, active low
	input  wire logic                  i_clk_en,                      // freezes all state when low
	input  wire logic [1:0]            i_level1_direction_sel,        // level 1 selection
	input  wire logic [1:0]            i_level2_direction_sel,        // level 2 selection
	input  wire logic [1:0]            i_level3_direction_sel,        // level 3 selection
	input  wire logic [1:0]            i_level4_direction_sel,        // level 4 selection
	input  wire logic [1:0]            i_directional_ctrl_enable_sel, // global enable
	input  wire dlr_pkg::dlr_points_type i_points,                    // decision points
	output dlr_pkg::dlr_out_type       o_ctrl,                        // per-level directional control
	output logic                       o_auto_settings_active,        // derived settings in use
	output logic                       o_settings_locked              // derived settings locked
);
	import dlr_pkg::*;

	dlr_state_type state_q;
	dlr_state_type state_d;
	logic [1:0]    sel [NUM_LEVELS];
	logic          neg_fwd;  // negative-sequence forward point after override
	logic          neg_rev;  // negative-sequence reverse point
	logic          ph_fwd;   // phase forward point after priority and override
	logic          ph_rev;   // phase reverse point after priority

	// any code other than forward or reverse counts as nondirectional
	function automatic logic route(input logic [1:0] s, input logic f, input logic r);
		if (s == DIR_FORWARD) begin
			return f; // [RULE_02]
		end else if (s == DIR_REVERSE) begin
			return r; // [RULE_02]
		end
		return 1'b1; // [RULE_01] [RULE_03] [RULE_14]
	endfunction : route

	// global disable overrides every level selection
	always_comb begin
		sel[0] = i_level1_direction_sel;
		sel[1] = i_level2_direction_sel;
		sel[2] = i_level3_direction_sel;
		sel[3] = i_level4_direction_sel;
		if (i_directional_ctrl_enable_sel != DCE_ENABLE && i_directional_ctrl_enable_sel != DCE_AUTO) begin
			for (int k = 0; k < NUM_LEVELS; k++) begin
				sel[k] = DIR_NONDIR; // [RULE_06] [RULE_07]
			end
		end
	end

	// potential loss override and negative-sequence priority shape the points
	always_comb begin
		neg_fwd = i_points.negseq_forward_point;
		neg_rev = i_points.negseq_reverse_point;
		// positive-sequence element only speaks when negative-sequence is not enabled
		ph_fwd = i_points.negseq_internal_enable ? neg_fwd
			: i_points.posseq_forward_point; // [RULE_12]
		ph_rev = i_points.negseq_internal_enable ? neg_rev
			: i_points.posseq_reverse_point; // [RULE_12]
		// reverse points stay untouched so reverse-set levels keep supervision during potential loss
		if (i_points.potential_loss_override_en && i_points.potential_lost_flag) begin
			neg_fwd = 1'h1; // [RULE_11]
			ph_fwd  = 1'h1; // [RULE_11]
		end
	end

	// next state: routing plus automatic-mode lock tracking
	always_comb begin
		state_d = state_q;
		for (int k = 0; k < NUM_LEVELS; k++) begin
			state_d.out.negseq_level[k] = route(sel[k], neg_fwd, neg_rev);
			state_d.out.phase_level[k]  = route(sel[k], ph_fwd, ph_rev);
			state_d.out.ground_level[k] = route(sel[k], i_points.ground_forward_point,
				i_points.ground_reverse_point);
		end
		// time-overcurrent elements all follow level 1
		state_d.out.toc_phase  = route(sel[0], ph_fwd, ph_rev); // [RULE_04]
		state_d.out.toc_negseq = route(sel[0], neg_fwd, neg_rev); // [RULE_04]
		state_d.out.toc_ground = route(sel[0], i_points.ground_forward_point,
			i_points.ground_reverse_point); // [RULE_04]
		state_d.out.sup_phase  = route(sel[1], ph_fwd, ph_rev); // [RULE_05]
		state_d.out.sup_negseq = route(sel[1], neg_fwd, neg_rev); // [RULE_05]
		state_d.out.sup_ground = route(sel[1], i_points.ground_forward_point,
			i_points.ground_reverse_point); // [RULE_05]
		state_d.auto_active = (i_directional_ctrl_enable_sel == DCE_AUTO); // [RULE_08]
		state_d.prev_enable = i_directional_ctrl_enable_sel;
		// lock holds through automatic; only a move to plain enabled releases it
		if (i_directional_ctrl_enable_sel == DCE_AUTO) begin
			state_d.settings_locked = 1'b1; // [RULE_09]
		end else if (state_q.prev_enable == DCE_AUTO && i_directional_ctrl_enable_sel == DCE_ENABLE) begin
			state_d.settings_locked = 1'b0; // [RULE_09]
		end
	end

	// one register stage; reset reads as nondirectional everywhere
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= '{out: '{negseq_level: RST_LEVEL_OUT, phase_level: RST_LEVEL_OUT,
				ground_level: RST_LEVEL_OUT, toc_phase: 1'b1, toc_ground: 1'b1, toc_negseq: 1'b1,
				sup_phase: 1'b1, sup_ground: 1'b1, sup_negseq: 1'b1},
				auto_active: 1'b0, settings_locked: RST_LOCK, prev_enable: DCE_DISABLE}; // [RULE_13]
		end else if (i_clk_en) begin
			state_q <= state_d; // [RULE_13]
		end
	end

	assign o_ctrl                 = state_q.out;
	assign o_auto_settings_active = state_q.auto_active;
	assign o_settings_locked      = state_q.settings_locked;

	a_nondir_level_high: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_03]
		(i_clk_en && i_level3_direction_sel == DIR_NONDIR) |=> (o_ctrl.phase_level[2] && o_ctrl.negseq_level[2]))
		else $error("nondirectional level 3 output not high");

	a_disable_all_high: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_07]
		(i_clk_en && i_directional_ctrl_enable_sel == DCE_DISABLE) |=> (&o_ctrl.ground_level && &o_ctrl.phase_level
		&& &o_ctrl.negseq_level))
		else $error("disabled control left a level output low");

	a_forward_routes: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_02]
		(i_clk_en && i_directional_ctrl_enable_sel == DCE_ENABLE && i_level1_direction_sel == DIR_FORWARD
		&& !i_points.potential_lost_flag) |=> (o_ctrl.negseq_level[0] == $past(i_points.negseq_forward_point)))
		else $error("forward level 1 did not follow negseq forward point");

	a_reverse_routes: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_02]
		(i_clk_en && i_directional_ctrl_enable_sel == DCE_ENABLE && i_level2_direction_sel == DIR_REVERSE)
		|=> (o_ctrl.ground_level[1] == $past(i_points.ground_reverse_point)))
		else $error("reverse level 2 did not follow ground reverse point");

	a_unused_code: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_14]
		(i_clk_en && i_level4_direction_sel == 2'h3) |=> o_ctrl.phase_level[3])
		else $error("unused selection code not nondirectional");

	a_potential_override: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_11]
		(i_clk_en && i_points.potential_loss_override_en && i_points.potential_lost_flag
		&& i_level1_direction_sel == DIR_FORWARD) |=> (o_ctrl.phase_level[0] && o_ctrl.negseq_level[0]))
		else $error("loss of potential override not applied");

	a_toc_follows_l1: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_04]
		i_clk_en |=> (o_ctrl.toc_phase == o_ctrl.phase_level[0] && o_ctrl.toc_negseq == o_ctrl.negseq_level[0]))
		else $error("time-overcurrent supervision differs from level 1");

	a_sup_follows_l2: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_05]
		i_clk_en |=> (o_ctrl.sup_ground == o_ctrl.ground_level[1] && o_ctrl.sup_phase == o_ctrl.phase_level[1]))
		else $error("supervisory outputs differ from level 2");

	a_negseq_priority: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_12]
		(i_clk_en && i_points.negseq_internal_enable && !i_points.potential_lost_flag
		&& i_directional_ctrl_enable_sel == DCE_ENABLE && i_level1_direction_sel == DIR_FORWARD)
		|=> (o_ctrl.phase_level[0] == $past(i_points.negseq_forward_point)))
		else $error("phase path ignored negseq priority");

	a_lock_holds: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_09]
		(i_clk_en && o_settings_locked && i_directional_ctrl_enable_sel != DCE_ENABLE) |=> o_settings_locked)
		else $error("settings lock released without move to enabled");

	a_auto_flag: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_08]
		(i_clk_en && i_directional_ctrl_enable_sel == DCE_AUTO) |=> (o_auto_settings_active && o_settings_locked))
		else $error("automatic mode not flagged");

	// the lock release takes two steps: an automatic cycle, then a plain enabled one
	// both steps must be clock-enabled cycles, since a frozen edge does not move the history
	sequence s_auto_step;
		i_clk_en && i_directional_ctrl_enable_sel == DCE_AUTO;
	endsequence

	sequence s_enable_step;
		i_clk_en && i_directional_ctrl_enable_sel == DCE_ENABLE;
	endsequence

	a_lock_release: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_09]
		s_auto_step ##1 s_enable_step |=> !o_settings_locked)
		else $error("direct move from automatic to enabled kept the lock");

	a_auto_flag_clear: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_08]
		(i_clk_en && i_directional_ctrl_enable_sel != DCE_AUTO) |=> !o_auto_settings_active)
		else $error("automatic flag stayed up outside automatic mode");

	// time-overcurrent supervision opens with level 1 alone, whatever levels 2 to 4 say
	a_toc_nondir_high: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_04]
		(i_clk_en && i_level1_direction_sel == DIR_NONDIR)
		|=> (o_ctrl.toc_phase && o_ctrl.toc_ground && o_ctrl.toc_negseq))
		else $error("time-overcurrent supervision closed with level 1 nondirectional");

	a_sup_reverse: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_05]
		(i_clk_en && i_directional_ctrl_enable_sel == DCE_ENABLE && i_level2_direction_sel == DIR_REVERSE)
		|=> (o_ctrl.sup_negseq == $past(i_points.negseq_reverse_point)
		&& o_ctrl.sup_ground == $past(i_points.ground_reverse_point)))
		else $error("supervisory outputs ignored the reverse points");

	a_disable_aux_high: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_07]
		(i_clk_en && i_directional_ctrl_enable_sel == DCE_DISABLE) |=> (o_ctrl.toc_phase && o_ctrl.toc_ground
		&& o_ctrl.toc_negseq && o_ctrl.sup_phase && o_ctrl.sup_ground && o_ctrl.sup_negseq))
		else $error("disabled control left a supervision output low");

	// the spare enable code reads as disable, so a corrupted setting fails open, never blocking
	a_unused_enable: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_06]
		(i_clk_en && i_directional_ctrl_enable_sel == 2'h3) |=> (&o_ctrl))
		else $error("spare enable code did not act as disable");

	a_posseq_path: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_12]
		(i_clk_en && !i_points.negseq_internal_enable && !i_points.potential_lost_flag
		&& i_directional_ctrl_enable_sel == DCE_ENABLE && i_level1_direction_sel == DIR_FORWARD)
		|=> (o_ctrl.phase_level[0] == $past(i_points.posseq_forward_point)))
		else $error("phase path did not use positive-sequence point");

	// the override only opens forward-set levels; reverse supervision must survive potential loss
	a_loss_keeps_reverse: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_11]
		(i_clk_en && i_points.potential_loss_override_en && i_points.potential_lost_flag
		&& i_directional_ctrl_enable_sel == DCE_ENABLE && i_level2_direction_sel == DIR_REVERSE)
		|=> (o_ctrl.negseq_level[1] == $past(i_points.negseq_reverse_point)))
		else $error("loss of potential override touched a reverse level");

	// a low enable must hold every flop, lock tracking included
	a_gate_freezes: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_13]
		!i_clk_en |=> ($stable(o_ctrl) && $stable(o_auto_settings_active) && $stable(o_settings_locked)))
		else $error("outputs moved while the clock enable was low");

	// every level, every family: a level without direction leaves its elements free
	for (genvar k = 0; k < NUM_LEVELS; k++) begin : g_level_chk
		a_level_nondir: assert property (@(posedge i_sys_clk) disable iff (!i_resetn) // [RULE_03]
			(i_clk_en && sel[k] != DIR_FORWARD && sel[k] != DIR_REVERSE)
			|=> (o_ctrl.phase_level[k] && o_ctrl.negseq_level[k] && o_ctrl.ground_level[k]))
			else $error("nondirectional level left an output low");
	end
endmodule : dlr_router

/* hw/dlr_pkg.sv */
/*
 * dlr_pkg: constants, encodings and carrier structs for the directional level router.
 * assumes one 20 MHz processing clock and an active-low asynchronous reset.
 */
// How it works
// [RULE_01] each of four level selections takes forward, reverse or nondirectional
// [RULE_02] forward levels gate with forward points, reverse levels with reverse points
// [RULE_03] nondirectional level holds its directional control outputs at one
// [RULE_04] all time-overcurrent elements follow the level 1 selection only
// [RULE_05] level 2 also steers supervisory elements; levels 3 and 4 steer their own
// [RULE_06] global enable takes three values: enabled, disabled, automatic
// [RULE_07] global disable forces every level, ground paths too, to nondirectional
// [RULE_08] automatic mode flags that eleven derived settings come from the device
// [RULE_09] derived settings stay locked until enable moves from automatic to enabled
// [RULE_10] configuring party supplies level selections, priority order, pickup, aux enable
// [RULE_11] potential loss with override enabled forces forward points to one; code forces negseq and phase, leaves ground forward point as is
// [RULE_12] negative-sequence enable disables the positive-sequence phase decision
// [RULE_13] outputs computed combinationally, registered once per clock, reset asserted
// [RULE_14] selections are two bits; the unused code means nondirectional
package dlr_pkg;
	localparam int NUM_LEVELS = 4;
	localparam int SEL_W      = 2;

	// level direction selection codes
	localparam logic [1:0] DIR_NONDIR  = 2'h0;
	localparam logic [1:0] DIR_FORWARD = 2'h1;
	localparam logic [1:0] DIR_REVERSE = 2'h2;

	// global directional control enable codes
	localparam logic [1:0] DCE_DISABLE = 2'h0;
	localparam logic [1:0] DCE_ENABLE  = 2'h1;
	localparam logic [1:0] DCE_AUTO    = 2'h2;

	// values after reset
	localparam logic [3:0] RST_LEVEL_OUT = 4'hf;
	localparam logic       RST_LOCK      = 1'h0;

	typedef struct packed {
		logic negseq_forward_point;
		logic negseq_reverse_point;
		logic posseq_forward_point;
		logic posseq_reverse_point;
		logic negseq_internal_enable;
		logic potential_loss_override_en;
		logic potential_lost_flag;
		logic ground_forward_point;
		logic ground_reverse_point;
	} dlr_points_type;

	typedef struct packed {
		logic [3:0] negseq_level;  // instantaneous and timed negative-sequence per level
		logic [3:0] phase_level;   // instantaneous and timed phase per level
		logic [3:0] ground_level;  // neutral and residual ground per level
		logic       toc_phase;     // time-overcurrent supervision, level 1
		logic       toc_ground;
		logic       toc_negseq;
		logic       sup_phase;     // level 2 supervisory variants
		logic       sup_ground;
		logic       sup_negseq;
	} dlr_out_type;

	typedef struct packed {
		dlr_out_type out;
		logic        auto_active;
		logic        settings_locked;
		logic [1:0]  prev_enable;
	} dlr_state_type;
endpackage : dlr_pkg

/* tb/dlr_points_model.sv */
/*
 * dlr_points_model: far-side directional elements that present decision points to the router.
 * assumes the bench hands it the wanted points; it publishes them on the falling edge.
 */
`timescale 1ns/1ps
module dlr_points_model (
	input  wire logic                    i_sys_clk, // processing clock
	input  wire dlr_pkg::dlr_points_type i_req,     // points the bench wants shown
	output dlr_pkg::dlr_points_type      o_points   // points seen by the router
);
	import dlr_pkg::*;
	// publish away from the rising edge so the router never samples a changing point
	always @(negedge i_sys_clk) begin
		o_points <= i_req;
	end
endmodule : dlr_points_model

/* tb/directional_level_routing_test.sv */
/*
 * directional_level_routing_test: self-checking bench for the directional level router.
 * assumes dlr_pkg and dlr_router from hw/ and the points model beside this file.
 */
`timescale 1ns/1ps
module directional_level_routing_test;
	import dlr_pkg::*;
	logic             i_sys_clk, i_resetn, i_clk_en, exp_lock;
	logic [3:0][1:0]  sel;
	logic [1:0]       en_sel, prev_en;
	dlr_points_type   req, pts;
	dlr_out_type      o_ctrl;
	logic             o_auto, o_lock;
	logic [19:0]      last_exp;
	int               err_total, checks_done;
	dlr_router u_dlr_router (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_clk_en(i_clk_en),
		.i_level1_direction_sel(sel[0]), .i_level2_direction_sel(sel[1]), .i_level3_direction_sel(sel[2]),
		.i_level4_direction_sel(sel[3]), .i_directional_ctrl_enable_sel(en_sel), .i_points(pts),
		.o_ctrl(o_ctrl), .o_auto_settings_active(o_auto), .o_settings_locked(o_lock));
	dlr_points_model u_dlr_points_model (.i_sys_clk(i_sys_clk), .i_req(req), .o_points(pts));
	// clock at 50 ns
	initial begin
		i_sys_clk = 1'b0;
		forever #25 i_sys_clk = ~i_sys_clk;
	end
	// lock expectation: set by auto, released only by a direct auto to enable step
	always @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			exp_lock <= 1'b0;
			prev_en  <= DCE_DISABLE;
		end else if (i_clk_en) begin
			exp_lock <= (en_sel == DCE_AUTO) | (exp_lock & !(prev_en == DCE_AUTO && en_sel == DCE_ENABLE));
			prev_en  <= en_sel;
		end
	end
	function automatic logic pick(input logic [1:0] s, input logic f, input logic r);
		return (s == DIR_FORWARD) ? f : (s == DIR_REVERSE) ? r : 1'b1;
	endfunction : pick
	function automatic dlr_out_type exp_out(input logic [3:0][1:0] s, input logic [1:0] e, input dlr_points_type p);
		dlr_out_type x;
		logic        ovr, pf, pr;
		ovr = p.potential_loss_override_en & p.potential_lost_flag;
		pf  = (p.negseq_internal_enable ? p.negseq_forward_point : p.posseq_forward_point) | ovr;
		pr  = p.negseq_internal_enable ? p.negseq_reverse_point : p.posseq_reverse_point;
		if (e != DCE_ENABLE && e != DCE_AUTO) s = {4{DIR_NONDIR}};
		for (int k = 0; k < 4; k++) begin
			x.negseq_level[k] = pick(s[k], p.negseq_forward_point | ovr, p.negseq_reverse_point);
			x.phase_level[k]  = pick(s[k], pf, pr);
			x.ground_level[k] = pick(s[k], p.ground_forward_point, p.ground_reverse_point);
		end
		x.toc_phase  = x.phase_level[0];
		x.toc_ground = x.ground_level[0];
		x.toc_negseq = x.negseq_level[0];
		x.sup_phase  = x.phase_level[1];
		x.sup_ground = x.ground_level[1];
		x.sup_negseq = x.negseq_level[1];
		return x;
	endfunction : exp_out
	task automatic check(input logic [19:0] exp);
		checks_done++;
		if ({o_ctrl, o_auto, o_lock} !== exp) begin
			err_total++;
			$display("[ERR] %0t outputs %h expected %h", $time, {o_ctrl, o_auto, o_lock}, exp);
		end
	endtask : check
	// apply settings and points, let the model and two router edges pass, then compare
	task automatic step(input logic [3:0][1:0] s, input logic [1:0] e, input dlr_points_type p);
		@(negedge i_sys_clk);
		sel    <= s;
		en_sel <= e;
		req    <= p;
		@(negedge i_sys_clk);
		@(negedge i_sys_clk);
		last_exp = {exp_out(s, e, p), e == DCE_AUTO, exp_lock};
		check(last_exp);
	endtask : step
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : conclude
	// watchdog well beyond the expected 811 cycles
	initial begin
		#400000;
		err_total++;
		conclude();
	end
	initial begin
		i_resetn = 1'h0;
		i_clk_en = 1'h0;
		sel      = '0;
		en_sel   = DCE_DISABLE;
		req      = '0;
		repeat (8) @(negedge i_sys_clk);
		check({RST_LEVEL_OUT, RST_LEVEL_OUT, RST_LEVEL_OUT, 6'h3f, 1'b0, RST_LOCK});
		i_resetn <= 1'b1;
		i_clk_en <= 1'b1;
		for (int i = 0; i < 256; i++) step(8'(i * 37), 2'(i >> 6), 9'((i * 91) ^ (i >> 2)));
		$display("sweep done");
		repeat (4) step(8'h94, DCE_AUTO, 9'h1a5);
		step(8'h55, DCE_DISABLE, 9'h0f3);
		step(8'haa, DCE_ENABLE, 9'h12c);
		step(8'h65, DCE_AUTO, 9'h0c6);
		step(8'h19, DCE_ENABLE, 9'h1d9);
		$display("lock sequence done");
		// new settings under a low enable must leave the last outputs standing
		@(negedge i_sys_clk);
		i_clk_en <= 1'h0;
		sel      <= 8'h66;
		en_sel   <= DCE_AUTO;
		req      <= 9'h000;
		repeat (3) @(negedge i_sys_clk);
		check(last_exp);
		i_clk_en <= 1'h1;
		$display("hold test done");
		step(8'h99, DCE_ENABLE, 9'h1ff);
		i_resetn <= 1'h0;
		@(negedge i_sys_clk);
		check({RST_LEVEL_OUT, RST_LEVEL_OUT, RST_LEVEL_OUT, 6'h3f, 1'h0, RST_LOCK});
		i_resetn <= 1'h1;
		step(8'h65, DCE_AUTO, 9'h0c6);
		$display("reset test done");
		conclude();
	end
endmodule : directional_level_routing_test
